// [hw/ifs_pkg.sv]
// Constants, field layouts and carrier types of the intermittent fault stage.
// Assumes a 10 MHz system clock and samples in signed Q4.12 per unit.
// Function
// - Residual voltage and current arrive as per-unit samples on a 5 ms time base.
// - Current channel selector: value 1 picks channel one (default), 2 channel two.
// - With override enabled, force code imposes normal, blocked, forward, reverse or trip.
// - Each program cycle, buffer peak of each channel is compared with its threshold.
// - Voltage threshold 1.00 to 100.00 percent, step 0.01, default 80.00.
// - Current threshold 0.05 to 40.00 times nominal, step 0.01, default 0.50.
// - Start only when unblocked and both spike thresholds are exceeded.
// - Condition code: 0 normal, 1 forward, 2 reverse, 3 trip, 4 blocked.
// - Voltage channel indicator: 1 input three, 2 input four, 0 none available.
// - Remaining time to trip shown counting down, 0 to 1800 s, 5 ms step.
// - Spikes still needed before trip shown as unsigned 32-bit value.
// - Blocking input sampled once at the start of every program cycle.
// - Blocking at pick-up asserts blocked and suppresses start and timing.
// - Blocking during start clears start and releases as if pick-up dropped.
// - Blocking issues a display event and a block record with values and type.
// - Fixed delay operation trips after the delay while pick-up stays active.
// - Forward hold timer, default 0.300 s, restarts per forward spike, clears forward start.
// - Reverse hold timer, default 0.300 s, restarts per reverse spike, clears reverse start.
// - Operate timer, default 0.500 s, runs from onset while forward start holds.
// - Trip needs forward spike count above setting 1 to 50, default 2.
// - Operate time reached with too few spikes: no trip, release at hold expiry.
// - Spike opposite to voltage is forward, same polarity is reverse.
// - On and off events for fault, forward, reverse, trip and blocked changes.
package ifs_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned TIME_BASE_NS    = 5_000_000;
    localparam int unsigned TICK_CYCLES_DEF = TIME_BASE_NS / CLK_PERIOD_NS;
    localparam int unsigned TIME_STEP_MS    = 5;
    localparam int unsigned FWD_HOLD_MS     = 300;
    localparam int unsigned REV_HOLD_MS     = 300;
    localparam int unsigned OP_DELAY_MS     = 500;
    localparam int unsigned MAX_TIME_MS     = 1_800_000;

    localparam int unsigned MAG_W = 16;
    localparam int unsigned TMR_W = 19;
    typedef logic [MAG_W-1:0] ifs_mag_t;
    typedef logic [TMR_W-1:0] ifs_tmr_t;
    typedef logic [13:0]      ifs_vthr_t;
    typedef logic [11:0]      ifs_ithr_t;
    typedef logic [5:0]       ifs_spk_t;
    typedef logic [31:0]      ifs_word_t;

    // Per-unit scale of a sample and threshold scales
    localparam ifs_word_t PU_ONE      = 32'h0000_1000;
    localparam ifs_word_t VTHR_SCALE  = 32'h0000_2710;
    localparam ifs_word_t ITHR_SCALE  = 32'h0000_0064;

    localparam ifs_vthr_t VTHR_MIN = 14'h0064;
    localparam ifs_vthr_t VTHR_MAX = 14'h2710;
    localparam ifs_vthr_t VTHR_RST = 14'h1f40;
    localparam ifs_ithr_t ITHR_MIN = 12'h005;
    localparam ifs_ithr_t ITHR_MAX = 12'hfa0;
    localparam ifs_ithr_t ITHR_RST = 12'h032;
    localparam ifs_spk_t  SPK_MIN  = 6'h01;
    localparam ifs_spk_t  SPK_MAX  = 6'h32;
    localparam ifs_spk_t  SPK_RST  = 6'h02;
    localparam ifs_tmr_t  TMR_MAX  = ifs_tmr_t'(MAX_TIME_MS / TIME_STEP_MS);
    localparam ifs_tmr_t  FWD_RST  = ifs_tmr_t'(FWD_HOLD_MS / TIME_STEP_MS);
    localparam ifs_tmr_t  REV_RST  = ifs_tmr_t'(REV_HOLD_MS / TIME_STEP_MS);
    localparam ifs_tmr_t  OPD_RST  = ifs_tmr_t'(OP_DELAY_MS / TIME_STEP_MS);

    // Register word addresses
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_VTHR   = 4'h1;
    localparam logic [3:0] A_ITHR   = 4'h2;
    localparam logic [3:0] A_FHOLD  = 4'h3;
    localparam logic [3:0] A_RHOLD  = 4'h4;
    localparam logic [3:0] A_OPDLY  = 4'h5;
    localparam logic [3:0] A_SPKSET = 4'h6;
    localparam logic [3:0] A_STAT   = 4'h7;
    localparam logic [3:0] A_TREM   = 4'h8;
    localparam logic [3:0] A_SREM   = 4'h9;
    localparam logic [3:0] A_FCNT   = 4'ha;
    localparam logic [3:0] A_RCNT   = 4'hb;

    // Control word fields
    localparam int unsigned CTRL_FEN  = 0;
    localparam int unsigned CTRL_FCD  = 1;
    localparam int unsigned CTRL_ISEL = 4;
    localparam int unsigned CTRL_VSEL = 6;
    localparam logic [1:0]  ISEL_RST  = 2'h1;
    localparam logic [1:0]  ISEL_TWO  = 2'h2;
    localparam logic [1:0]  VSEL_RST  = 2'h1;
    localparam logic [1:0]  VSEL_NONE = 2'h0;
    localparam logic [1:0]  VSEL_MAX  = 2'h2;

    // Force codes
    localparam logic [2:0] FRC_NORMAL = 3'h0;
    localparam logic [2:0] FRC_BLOCK  = 3'h1;
    localparam logic [2:0] FRC_FWD    = 3'h2;
    localparam logic [2:0] FRC_REV    = 3'h3;
    localparam logic [2:0] FRC_TRIP   = 3'h4;
    // Condition codes
    localparam logic [2:0] CND_NORMAL = 3'h0;
    localparam logic [2:0] CND_FWD    = 3'h1;
    localparam logic [2:0] CND_REV    = 3'h2;
    localparam logic [2:0] CND_TRIP   = 3'h3;
    localparam logic [2:0] CND_BLOCK  = 3'h4;

    typedef struct packed {
        logic            valid;
        logic [15:0]     volt;
        logic [15:0]     cur_one;
        logic [15:0]     cur_two;
    } ifs_smp_t;

    // Bit order: blocked, trip, reverse, forward, fault detected
    typedef struct packed {
        logic            blocked;
        logic            trip;
        logic            rev_start;
        logic            fwd_start;
        logic            fault_det;
    } ifs_stat_t;

    typedef struct packed {
        ifs_stat_t       on;
        ifs_stat_t       off;
    } ifs_evt_t;

    typedef struct packed {
        logic            valid;
        ifs_mag_t        volt_mag;
        ifs_mag_t        cur_mag;
        logic            fault_fwd;
    } ifs_rec_t;

endpackage

// [hw/ifs_stage.sv]
// Intermittent earth fault stage: spike detection, hold and operate timers,
// blocking, status forcing, events and a small register file.
// Assumes samples and bus on i_sys_clk; blocking comes from another domain.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ifs_stage #(
    parameter int unsigned TICK_CYCLES = ifs_pkg::TICK_CYCLES_DEF
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire ifs_pkg::ifs_smp_t i_smp,
    input  wire logic              i_block,
    input  wire logic [3:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_we,
    input  wire logic              i_re,
    output logic [31:0]            o_rdata,
    output ifs_pkg::ifs_stat_t     o_stat,
    output logic [2:0]             o_cond,
    output logic [1:0]             o_volt_chan,
    output ifs_pkg::ifs_evt_t      o_evt,
    output ifs_pkg::ifs_rec_t      o_blk_rec,
    output logic                   o_tick,
    output ifs_pkg::ifs_tmr_t      o_time_rem,
    output logic [31:0]            o_spk_rem
);

    typedef struct packed {
        logic [31:0]         tick_cnt;
        logic                tick;
        logic                blk_meta;
        logic                blk_sync;
        logic                blk;
        ifs_pkg::ifs_mag_t   upk;
        logic                uneg;
        ifs_pkg::ifs_mag_t   ipk;
        logic                ineg;
        logic                frc_en;
        logic [2:0]          frc_code;
        logic [1:0]          isel;
        logic [1:0]          vsel;
        ifs_pkg::ifs_vthr_t  vthr;
        ifs_pkg::ifs_ithr_t  ithr;
        ifs_pkg::ifs_tmr_t   fhold;
        ifs_pkg::ifs_tmr_t   rhold;
        ifs_pkg::ifs_tmr_t   opdly;
        ifs_pkg::ifs_spk_t   spkset;
        logic                fwd;
        logic                rev;
        logic                trip;
        logic                blocked;
        ifs_pkg::ifs_tmr_t   ftmr;
        ifs_pkg::ifs_tmr_t   rtmr;
        ifs_pkg::ifs_tmr_t   opel;
        logic [31:0]         fcnt;
        logic [31:0]         rcnt;
        ifs_pkg::ifs_stat_t  shown;
        ifs_pkg::ifs_evt_t   evt;
        ifs_pkg::ifs_rec_t   rec;
        logic [31:0]         rdata;
    } ifs_state_t;

    localparam ifs_state_t ST_RESET = '{
        isel:    ifs_pkg::ISEL_RST,
        vsel:    ifs_pkg::VSEL_RST,
        vthr:    ifs_pkg::VTHR_RST,
        ithr:    ifs_pkg::ITHR_RST,
        fhold:   ifs_pkg::FWD_RST,
        rhold:   ifs_pkg::REV_RST,
        opdly:   ifs_pkg::OPD_RST,
        spkset:  ifs_pkg::SPK_RST,
        default: '0
    };

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    ifs_state_t q;
    ifs_state_t d;

    function automatic ifs_pkg::ifs_mag_t mag_of(input logic [15:0] s);
        mag_of = s[15] ? ifs_pkg::ifs_mag_t'(~s + 16'h0001) : s;
    endfunction

    // Peak in per unit above a threshold given in steps of 1/scale
    function automatic logic above(input ifs_pkg::ifs_mag_t mag,
                                   input logic [13:0] thr,
                                   input logic [31:0] scale);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs   = {16'h0000, mag} * scale;
        rhs   = {18'h00000, thr} * ifs_pkg::PU_ONE;
        above = lhs > rhs;
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
    endfunction

    // Derived views, shared by the next-state logic and the outputs
    ifs_pkg::ifs_stat_t shown_now;
    logic [2:0]         cond_now;
    ifs_pkg::ifs_tmr_t  trem_now;
    logic [31:0]        srem_now;
    logic [31:0]        need;

    always_comb begin
        shown_now = '0;
        if (q.frc_en) begin
            unique case (q.frc_code)
                ifs_pkg::FRC_BLOCK: shown_now.blocked   = 1'b1;
                ifs_pkg::FRC_FWD:   shown_now.fwd_start = 1'b1;
                ifs_pkg::FRC_REV:   shown_now.rev_start = 1'b1;
                ifs_pkg::FRC_TRIP:  shown_now.trip      = 1'b1;
                default:            shown_now           = '0;
            endcase
        end else begin
            shown_now.blocked   = q.blocked;
            shown_now.trip      = q.trip;
            shown_now.rev_start = q.rev;
            shown_now.fwd_start = q.fwd;
        end
        shown_now.fault_det = shown_now.fwd_start | shown_now.rev_start
                            | shown_now.trip;

        if (shown_now.blocked) begin
            cond_now = ifs_pkg::CND_BLOCK;
        end else if (shown_now.trip) begin
            cond_now = ifs_pkg::CND_TRIP;
        end else if (shown_now.fwd_start) begin
            cond_now = ifs_pkg::CND_FWD;
        end else if (shown_now.rev_start) begin
            cond_now = ifs_pkg::CND_REV;
        end else begin
            cond_now = ifs_pkg::CND_NORMAL;
        end

        // Idle shows the full delay, a running fault counts down
        if (!q.fwd) begin
            trem_now = q.opdly;
        end else if (q.opel >= q.opdly) begin
            trem_now = '0;
        end else begin
            trem_now = q.opdly - q.opel;
        end

        need = {26'h0000000, q.spkset} + 32'h0000_0001;
        srem_now = (q.fcnt >= need) ? 32'h0000_0000 : need - q.fcnt;
    end

    // Next state
    ifs_pkg::ifs_mag_t imag;
    logic              isgn;
    logic              vspike;
    logic              ispike;
    logic              pickup;
    logic              fspike;
    logic              rspike;
    logic              active;
    logic [31:0]       wclamp;

    always_comb begin
        d = q;

        // Two flops before the block level is used anywhere
        d.blk_meta = i_block;
        d.blk_sync = q.blk_meta;

        d.tick = (q.tick_cnt == TICK_LAST);
        d.tick_cnt = d.tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;

        // Circular buffer peak of the program cycle
        if (i_smp.cur_one != i_smp.cur_two && q.isel == ifs_pkg::ISEL_TWO) begin
            imag = mag_of(i_smp.cur_two);
            isgn = i_smp.cur_two[15];
        end else if (q.isel == ifs_pkg::ISEL_TWO) begin
            imag = mag_of(i_smp.cur_two);
            isgn = i_smp.cur_two[15];
        end else begin
            imag = mag_of(i_smp.cur_one);
            isgn = i_smp.cur_one[15];
        end
        if (q.tick) begin
            d.upk  = '0;
            d.uneg = 1'b0;
            d.ipk  = '0;
            d.ineg = 1'b0;
        end
        if (i_smp.valid) begin
            if (q.tick || mag_of(i_smp.volt) > q.upk) begin
                d.upk  = mag_of(i_smp.volt);
                d.uneg = i_smp.volt[15];
            end
            if (q.tick || imag > q.ipk) begin
                d.ipk  = imag;
                d.ineg = isgn;
            end
        end

        // Peak against threshold; no voltage channel means no pick-up
        vspike = (q.vsel != ifs_pkg::VSEL_NONE)
               && above(q.upk, q.vthr, ifs_pkg::VTHR_SCALE);
        ispike = above(q.ipk, {2'h0, q.ithr}, ifs_pkg::ITHR_SCALE);
        pickup = vspike && ispike;
        fspike = pickup && (q.uneg != q.ineg);
        rspike = pickup && (q.uneg == q.ineg);
        d.rec.valid = 1'b0;

        if (q.tick) begin
            d.blk = q.blk_sync;
            if (q.blk_sync) begin
                // Start cleared and timing dropped as on release
                d.fwd  = 1'b0;
                d.rev  = 1'b0;
                d.trip = 1'b0;
                d.ftmr = '0;
                d.rtmr = '0;
                d.opel = '0;
                d.fcnt = '0;
                d.rcnt = '0;
                d.blocked = q.blocked | pickup | q.fwd | q.rev;
                if (!q.blocked && d.blocked) begin
                    d.rec.valid     = 1'b1;
                    d.rec.volt_mag  = q.upk;
                    d.rec.cur_mag   = q.ipk;
                    d.rec.fault_fwd = fspike | q.fwd;
                end
            end else begin
                d.blocked = 1'b0;
                if (fspike) begin
                    d.fwd  = 1'b1;
                    d.ftmr = q.fhold;
                    d.fcnt = sat_inc(q.fcnt);
                end else if (q.fwd) begin
                    if (q.ftmr <= ifs_pkg::ifs_tmr_t'(1)) begin
                        d.fwd  = 1'b0;
                        d.ftmr = '0;
                    end else begin
                        d.ftmr = q.ftmr - ifs_pkg::ifs_tmr_t'(1);
                    end
                end
                if (rspike) begin
                    d.rev  = 1'b1;
                    d.rtmr = q.rhold;
                    d.rcnt = sat_inc(q.rcnt);
                end else if (q.rev) begin
                    if (q.rtmr <= ifs_pkg::ifs_tmr_t'(1)) begin
                        d.rev  = 1'b0;
                        d.rtmr = '0;
                    end else begin
                        d.rtmr = q.rtmr - ifs_pkg::ifs_tmr_t'(1);
                    end
                end

                // Operate timer from fault onset
                if (!d.fwd) begin
                    d.opel = '0;
                    d.trip = 1'b0;
                end else if (q.fwd && q.opel < q.opdly) begin
                    d.opel = q.opel + ifs_pkg::ifs_tmr_t'(1);
                end
                // Short of spikes, the trip waits for more or for release
                if (d.fwd && d.opel >= q.opdly
                    && d.fcnt > {26'h0000000, q.spkset}) begin
                    d.trip = 1'b1;
                end
            end
            active = d.fwd | d.rev;
            if (!active) begin
                d.fcnt = '0;
                d.rcnt = '0;
            end
        end else begin
            active = 1'b0;
        end

        // Edge events on the status as shown to the outside
        d.shown   = shown_now;
        d.evt.on  = shown_now & ~q.shown;
        d.evt.off = q.shown & ~shown_now;

        // Register writes, clamped into the settable ranges
        wclamp = 32'h0000_0000;
        if (i_we) begin
            unique case (i_addr)
                ifs_pkg::A_CTRL: begin
                    d.frc_en   = i_wdata[ifs_pkg::CTRL_FEN];
                    d.frc_code = i_wdata[ifs_pkg::CTRL_FCD +: 3];
                    d.isel = (i_wdata[ifs_pkg::CTRL_ISEL +: 2]
                              == ifs_pkg::ISEL_TWO)
                           ? ifs_pkg::ISEL_TWO : ifs_pkg::ISEL_RST;
                    d.vsel = (i_wdata[ifs_pkg::CTRL_VSEL +: 2]
                              > ifs_pkg::VSEL_MAX)
                           ? ifs_pkg::VSEL_NONE
                           : i_wdata[ifs_pkg::CTRL_VSEL +: 2];
                end
                ifs_pkg::A_VTHR: begin
                    wclamp = clamp(i_wdata, {18'h0, ifs_pkg::VTHR_MIN},
                                   {18'h0, ifs_pkg::VTHR_MAX});
                    d.vthr = wclamp[13:0];
                end
                ifs_pkg::A_ITHR: begin
                    wclamp = clamp(i_wdata, {20'h0, ifs_pkg::ITHR_MIN},
                                   {20'h0, ifs_pkg::ITHR_MAX});
                    d.ithr = wclamp[11:0];
                end
                ifs_pkg::A_FHOLD: begin
                    wclamp  = clamp(i_wdata, 32'h0, {13'h0, ifs_pkg::TMR_MAX});
                    d.fhold = wclamp[18:0];
                end
                ifs_pkg::A_RHOLD: begin
                    wclamp  = clamp(i_wdata, 32'h0, {13'h0, ifs_pkg::TMR_MAX});
                    d.rhold = wclamp[18:0];
                end
                ifs_pkg::A_OPDLY: begin
                    wclamp  = clamp(i_wdata, 32'h0, {13'h0, ifs_pkg::TMR_MAX});
                    d.opdly = wclamp[18:0];
                end
                ifs_pkg::A_SPKSET: begin
                    wclamp   = clamp(i_wdata, {26'h0, ifs_pkg::SPK_MIN},
                                     {26'h0, ifs_pkg::SPK_MAX});
                    d.spkset = wclamp[5:0];
                end
                default: wclamp = 32'h0000_0000;
            endcase
        end

        // Read data valid only in the cycle after the strobe
        d.rdata = 32'h0000_0000;
        if (i_re) begin
            unique case (i_addr)
                ifs_pkg::A_CTRL:   d.rdata = {24'h0, q.vsel, q.isel,
                                              q.frc_code, q.frc_en};
                ifs_pkg::A_VTHR:   d.rdata = {18'h0, q.vthr};
                ifs_pkg::A_ITHR:   d.rdata = {20'h0, q.ithr};
                ifs_pkg::A_FHOLD:  d.rdata = {13'h0, q.fhold};
                ifs_pkg::A_RHOLD:  d.rdata = {13'h0, q.rhold};
                ifs_pkg::A_OPDLY:  d.rdata = {13'h0, q.opdly};
                ifs_pkg::A_SPKSET: d.rdata = {26'h0, q.spkset};
                ifs_pkg::A_STAT:   d.rdata = {18'h0, q.blk, shown_now,
                                              2'h0, q.vsel, 1'b0, cond_now};
                ifs_pkg::A_TREM:   d.rdata = {13'h0, trem_now};
                ifs_pkg::A_SREM:   d.rdata = srem_now;
                ifs_pkg::A_FCNT:   d.rdata = q.fcnt;
                ifs_pkg::A_RCNT:   d.rdata = q.rcnt;
                default:           d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_rdata     = q.rdata;
    assign o_stat      = q.shown;
    assign o_cond      = cond_now;
    assign o_volt_chan = q.vsel;
    assign o_evt       = q.evt;
    assign o_blk_rec   = q.rec;
    assign o_tick      = q.tick;
    assign o_time_rem  = trem_now;
    assign o_spk_rem   = srem_now;

endmodule

`default_nettype wire

// [tb/ifs_stage_properties.sv]
// Output checker of the intermittent fault stage.
// Bound into ifs_stage; sees its ports only, one clock.
`timescale 1ns/10ps
`default_nettype none
module ifs_props (
    input wire logic               i_sys_clk,
    input wire logic               i_reset,
    input wire ifs_pkg::ifs_stat_t o_stat,
    input wire logic [2:0]         o_cond,
    input wire ifs_pkg::ifs_evt_t  o_evt,
    input wire ifs_pkg::ifs_rec_t  o_blk_rec,
    input wire logic [31:0]        o_spk_rem
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_rec;
        o_blk_rec.valid ##1 !o_blk_rec.valid;
    endsequence
    property p_blk; o_cond == 3'h4 |=> o_stat.blocked; endproperty
    a_blk: assert property (p_blk) else $error("blocked code");
    property p_trip; o_cond == 3'h3 |=> o_stat.trip; endproperty
    a_trip: assert property (p_trip) else $error("trip code");
    property p_fwd; o_cond == 3'h1 |=> o_stat.fwd_start; endproperty
    a_fwd: assert property (p_fwd) else $error("forward code");
    property p_rev; o_cond == 3'h2 |=> o_stat.rev_start; endproperty
    a_rev: assert property (p_rev) else $error("reverse code");
    property p_on; o_evt.on == (o_stat & ~$past(o_stat)); endproperty
    a_on: assert property (p_on) else $error("on event");
    // Skip the edge where the past value still predates reset
    property p_off; !$past(i_reset) |->
        o_evt.off == ($past(o_stat) & ~o_stat); endproperty
    a_off: assert property (p_off) else $error("off event");
    property p_quiet; o_stat.blocked |-> !o_stat.fwd_start; endproperty
    a_quiet: assert property (p_quiet) else $error("start when blocked");
    property p_rec; o_blk_rec.valid |-> s_rec; endproperty
    a_rec: assert property (p_rec) else $error("block record");
    property p_spk; o_spk_rem <= 32'h33; endproperty
    a_spk: assert property (p_spk) else $error("spikes left");
endmodule
bind ifs_stage ifs_props ifs_props_i (.i_sys_clk(i_sys_clk),
    .i_reset(i_reset), .o_stat(o_stat), .o_cond(o_cond), .o_evt(o_evt),
    .o_blk_rec(o_blk_rec), .o_spk_rem(o_spk_rem));
`default_nettype wire

// [tb/ifs_smp_src.sv]
// Residual sample source standing in for the measurement buffers.
// Assumes the bench holds mode for whole program cycles.
`timescale 1ns/10ps
`default_nettype none
module ifs_smp_src (
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    input  wire logic [1:0]   i_mode,
    input  wire logic         i_chan,
    output ifs_pkg::ifs_smp_t o_smp
);
    logic [15:0] cur;
    // 1 forward, 2 reverse, 3 current below threshold
    always_comb begin
        case (i_mode)
            2'h1: cur = 16'hf000;
            2'h2: cur = 16'h1000;
            2'h3: cur = 16'h0400;
            default: cur = 16'h0008;
        endcase
    end
    // A fresh sample every other clock
    always_ff @(posedge i_sys_clk) begin
        o_smp.valid <= !i_reset && !o_smp.valid;
        o_smp.volt <= (i_mode != 2'h0) ? 16'h1000 : 16'h0010;
        o_smp.cur_one <= i_chan ? 16'h0008 : cur;
        o_smp.cur_two <= i_chan ? cur : 16'h0008;
    end
endmodule
`default_nettype wire

// [tb/ifs_stage_test.sv]
// Self-checking bench of the intermittent fault stage.
// Assumes an 8 clock program cycle to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module ifs_stage_test;
    logic               i_sys_clk = 0, i_reset = 1, i_block = 0, chan = 0;
    logic               i_we = 0, i_re = 0, o_tick, rec_seen = 0;
    logic [3:0]         i_addr = 0;
    logic [31:0]        i_wdata = 0, o_rdata, o_spk_rem;
    logic [1:0]         mode = 0, o_volt_chan;
    logic [2:0]         o_cond;
    logic [15:0]        rnd = 16'h616f;
    ifs_pkg::ifs_smp_t  i_smp;
    ifs_pkg::ifs_stat_t o_stat;
    ifs_pkg::ifs_evt_t  o_evt;
    ifs_pkg::ifs_rec_t  o_blk_rec;
    ifs_pkg::ifs_tmr_t  o_time_rem;
    int                 error_cnt = 0, cmp_count = 0;
    logic [31:0]        rst_v [7] = '{'h50, 'h1f40, 'h32, 'h3c, 'h3c, 'h64, 2};
    ifs_stage #(.TICK_CYCLES(8)) ifs_stage_i (.i_sys_clk(i_sys_clk),
        .i_reset(i_reset), .i_smp(i_smp), .i_block(i_block), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
        .o_stat(o_stat), .o_cond(o_cond), .o_volt_chan(o_volt_chan),
        .o_evt(o_evt), .o_blk_rec(o_blk_rec), .o_tick(o_tick),
        .o_time_rem(o_time_rem), .o_spk_rem(o_spk_rem));
    ifs_smp_src ifs_smp_src_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_mode(mode), .i_chan(chan), .o_smp(i_smp));
    function automatic logic [31:0] clampv(logic [15:0] v);
        return (v < 100) ? 100 : (v > 10000) ? 10000 : 32'(v);
    endfunction
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, logic [31:0] d);
        @(posedge i_sys_clk);
        i_we <= w;
        i_re <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_we <= 0;
        i_re <= 0;
        #1 if (!w) chk("rdata", o_rdata, d);
    endtask
    // Whole program cycles counted on o_tick; the mode changes mid-cycle, at the call
    task automatic run(input logic [1:0] m, input int n);
        int k;
        mode = m;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge i_sys_clk);
                k++;
            end while (o_tick !== 1'b1 && k < 20);
            if (k >= 20) begin
                error_cnt++;
                end_sim();
            end
        end
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask
    initial forever #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_blk_rec.valid === 1'b1) rec_seen <= 1;
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 0;
        for (int a = 0; a < 7; a++) bus(0, 4'(a), rst_v[a]);
        chk("trem", 32'(o_time_rem), 32'h64);
        chk("vch", o_volt_chan, 1);
        bus(0, 4'hc, 0);
        repeat (4) begin
            rnd = lfsr(rnd);
            bus(1, 4'h1, 32'(rnd));
            bus(0, 4'h1, clampv(rnd));
        end
        bus(1, 4'h2, 32'hffff);
        bus(0, 4'h2, 32'hfa0);
        for (int k = 0; k < 5; k++) begin
            bus(1, 4'h0, 32'h51 | (k << 1));
            chk("frc", o_cond, (k == 1) ? 4 : (k == 0) ? 0 : k - 1);
        end
        for (int a = 1; a < 7; a++) bus(1, 4'(a), a < 3 ? rst_v[a] : 4 + a / 5);
        bus(1, 4'h6, 50);
        bus(1, 4'h0, 32'h50);
        run(1, 8);
        chk("fwd", o_stat, 5'h03);
        run(0, 8);
        chk("fwd", o_stat.fwd_start, 0);
        bus(1, 4'h6, 2);
        run(1, 10);
        chk("trip", o_stat.trip, 1);
        chk("spk", o_spk_rem, 0);
        run(0, 8);
        bus(0, 4'ha, 0);
        chk("trem", 32'(o_time_rem), 32'h5);
        run(2, 3);
        chk("cond", o_cond, 2);
        run(3, 8);
        chk("low", o_stat, 0);
        bus(1, 4'h0, 32'h60);
        run(1, 3);
        chk("chan", o_stat.fwd_start, 0);
        chan = 1;
        run(1, 2);
        chk("chan", o_stat.fwd_start, 1);
        chk("trem", 32'(o_time_rem), 32'h4);
        chk("spk", o_spk_rem, 1);
        @(posedge i_sys_clk) i_block <= 1;
        run(1, 2);
        chk("blk", o_stat, 5'h10);
        chk("rec", rec_seen, 1);
        chk("recm", {o_blk_rec.volt_mag, o_blk_rec.cur_mag},
            32'h1000_1000);
        chk("recf", o_blk_rec.fault_fwd, 1);
        @(posedge i_sys_clk) i_block <= 0;
        bus(1, 4'h0, 32'h10);
        run(1, 3);
        chk("vch", {o_volt_chan, o_stat}, 0);
        end_sim();
    end
endmodule
`default_nettype wire
